// File: link_fec_consts.vh
// constants for the 64b/66b fec sync header link block
`ifndef LINK_FEC_CONSTS_VH
`define LINK_FEC_CONSTS_VH

`define BLOCKS_PER_MB 32
`define BLOCK_PAYLOAD_BITS 64
`define PARITY_BITS 26
// generator x^26+x^21+x^17+x^9+x^4+1, low 26 coefficients
`define FEC_POLY 26'h0220211
`define PARITY_ZERO 26'h0000000
`define PAR_ZERO 26'h0000000

// sync header stream positions
`define SH_EMB_FLAG_POS 22
`define SH_PAR3_POS 23
`define SH_PILOT_POS 31
`define SH_PILOT_TAIL 5'h10

// two-bit headers, bit 0 sent first
`define HDR_ONE 2'h2
`define HDR_ZERO 2'h1

// axi4-lite map
`define ADDR_CTRL 4'h0
`define ADDR_EMPH 4'h4
`define ADDR_STAT 4'h8
`define ADDR_PARITY 4'hC
`define CTRL_EN_BIT 0
`define CTRL_FEC_BIT 1
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define EMPH_RESET 4'h0

`endif

// File: sync_header_fec_link_align.v
// fec parity, sync header stream, enable gating and sysref lemc alignment
// Operation
// - parity word per 32-block 2048-bit multiblock
// - parity sent in the following multiblock
// - detection latency at least 58 blocks
// - fixed bit mapping of fec sync stream
// - end flag set in last multiblock
// - generator x26+x21+x17+x9+x4+1, shortened code
// - clear register, payload only, result is parity
// - programmable pre-emphasis level to drivers
// - disabled link held reset, powered down, gated; mb_count_reg keeps its value while disabled
// - sysref resets the local extended multiblock clock
// - one multiblock per extended multiblock
// - header 01 sends one, 10 sends zero
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "link_fec_consts.vh"

module sync_header_fec_link_align #(
	parameter EMPH_W = 4
) (
	input wire CLK,
	input wire RST_N,
	input wire [31:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [31:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire SYSREF,
	input wire [63:0] PAYLOAD_DATA,
	input wire PAYLOAD_VALID,
	output reg PAYLOAD_READY,
	output reg [65:0] BLOCK_OUT,
	output reg BLOCK_VALID,
	output reg LEMC_PULSE,
	output reg SERIAL_LINK_ENABLE,
	output reg SERIALIZER_POWER_DOWN,
	output reg LINK_CLK_GATE_EN,
	output reg [EMPH_W-1:0] SERIALIZER_EMPHASIS_LEVEL
);

	reg link_en_reg;
	reg fec_mode_reg;
	reg [EMPH_W-1:0] emph_reg;
	reg [25:0] lfsr_reg;
	reg [25:0] lfsr_next;
	reg [25:0] parity_hold_reg;
	reg [4:0] blk_cnt_reg;
	reg [31:0] mb_count_reg;
	reg sysref_d_reg;
	reg aw_got_reg;
	reg w_got_reg;
	reg aw_hi_reg;
	reg [2:0] rd_state_reg;
	reg [3:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [31:0] sh_stream;
	reg [31:0] rd_word;
	reg sh_bit;
	integer i;
	integer j;

	// read channel states, one-hot
	localparam RD_IDLE = 3'b001;
	localparam RD_RESP = 3'b010;
	localparam RD_SPARE = 3'b100;

	wire link_live = link_en_reg & ~SERIAL_LINK_ENABLE ? 1'b0 : link_en_reg;
	// only the first four words exist; anything above is refused
	wire rd_hit = (S_AXI_ARADDR[31:4] == 28'h0000000) &
		(S_AXI_ARADDR[3:0] <= `ADDR_PARITY);
	wire sysref_rise = SYSREF & ~sysref_d_reg;
	wire take_blk = link_live & PAYLOAD_VALID & PAYLOAD_READY;
	wire wr_fire = aw_got_reg & w_got_reg & ~S_AXI_BVALID;
	wire [31:0] mb_last = `BLOCKS_PER_MB - 1;
	wire [4:0] last_blk = mb_last[4:0];

	// serial division by the generator, first sent bit first
	always @* begin
		lfsr_next = (blk_cnt_reg == 5'h00) ? `PARITY_ZERO : lfsr_reg;
		for (i = 0; i < `BLOCK_PAYLOAD_BITS; i = i + 1) begin
			if (lfsr_next[`PARITY_BITS-1] ^ PAYLOAD_DATA[i]) begin
				lfsr_next = {lfsr_next[24:0], 1'b0} ^ `FEC_POLY;
			end else begin
				lfsr_next = {lfsr_next[24:0], 1'b0};
			end
		end
	end

	// stream carries the previous multiblock's parity
	always @* begin
		sh_stream = 32'h00000000;
		for (j = 0; j < 22; j = j + 1) begin
			sh_stream[j] = parity_hold_reg[25-j];
		end
		sh_stream[`SH_EMB_FLAG_POS] = 1'b1;
		sh_stream[`SH_PAR3_POS] = parity_hold_reg[3];
		for (j = 0; j < 3; j = j + 1) begin
			sh_stream[24+j] = parity_hold_reg[2-j];
		end
		sh_stream[`SH_PILOT_POS] = 1'b1;
		// crc mode out of scope: non-fec shows pilot and end flag only
		if (!fec_mode_reg) begin
			sh_stream[26:0] = 27'h0000000;
			sh_stream[`SH_EMB_FLAG_POS] = 1'b1;
		end
		sh_bit = sh_stream[blk_cnt_reg];
	end

	always @* begin
		rd_word = 32'h00000000;
		case (S_AXI_ARADDR[3:0])
		`ADDR_CTRL: rd_word = {30'h00000000, fec_mode_reg, link_en_reg};
		`ADDR_EMPH: rd_word = {{(32-EMPH_W){1'b0}}, emph_reg};
		`ADDR_STAT: rd_word = {mb_count_reg[26:0], blk_cnt_reg};
		`ADDR_PARITY: rd_word = {6'h00, parity_hold_reg};
		default: rd_word = 32'h00000000;
		endcase
	end

	// axi4-lite slave, one write and one read at a time
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_hi_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h00000000;
			link_en_reg <= 1'b0;
			fec_mode_reg <= 1'b1;
			emph_reg <= {EMPH_W{1'b0}};
		end else begin
			S_AXI_AWREADY <= ~aw_got_reg & ~S_AXI_AWREADY & S_AXI_AWVALID;
			S_AXI_WREADY <= ~w_got_reg & ~S_AXI_WREADY & S_AXI_WVALID;
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR[3:0];
				// upper bits kept so aliases of the map are refused
				aw_hi_reg <= (S_AXI_AWADDR[31:4] == 28'h0000000);
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_got_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `RESP_OKAY;
				case (aw_hi_reg ? aw_addr_reg : 4'hF)
				`ADDR_CTRL: begin
					if (S_AXI_WSTRB[0]) begin
						link_en_reg <= w_data_reg[`CTRL_EN_BIT];
						// mode only changes while disabled
						if (!link_en_reg) begin
							fec_mode_reg <= w_data_reg[`CTRL_FEC_BIT];
						end
					end
				end
				`ADDR_EMPH: begin
					if (S_AXI_WSTRB[0] & ~link_en_reg) begin
						emph_reg <= w_data_reg[EMPH_W-1:0];
					end
				end
				`ADDR_STAT, `ADDR_PARITY: S_AXI_BRESP <= `RESP_OKAY;
				default: S_AXI_BRESP <= `RESP_DECERR;
				endcase
			end else if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// read channel: address and data answered together
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_state_reg <= RD_IDLE;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP <= `RESP_OKAY;
			S_AXI_RDATA <= 32'h00000000;
		end else begin
			S_AXI_ARREADY <= 1'b0;
			case (rd_state_reg)
			RD_IDLE: begin
				if (S_AXI_ARVALID) begin
					rd_state_reg <= RD_RESP;
					S_AXI_ARREADY <= 1'b1;
					S_AXI_RVALID <= 1'b1;
					S_AXI_RDATA <= rd_hit ? rd_word : 32'h00000000;
					S_AXI_RRESP <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
				end
			end
			RD_RESP: begin
				if (S_AXI_RREADY) begin
					rd_state_reg <= RD_IDLE;
					S_AXI_RVALID <= 1'b0;
				end
			end
			default: begin
				rd_state_reg <= RD_IDLE;
				S_AXI_RVALID <= 1'b0;
			end
			endcase
		end
	end

	// link datapath: lfsr, parity hold and block count held in reset while disabled, mb_count_reg kept
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lfsr_reg <= `PARITY_ZERO;
			parity_hold_reg <= `PAR_ZERO;
			blk_cnt_reg <= 5'h00;
			mb_count_reg <= 32'h00000000;
			sysref_d_reg <= 1'b0;
			BLOCK_OUT <= 66'h0;
			BLOCK_VALID <= 1'b0;
			LEMC_PULSE <= 1'b0;
			PAYLOAD_READY <= 1'b0;
			SERIAL_LINK_ENABLE <= 1'b0;
			SERIALIZER_POWER_DOWN <= 1'b1;
			LINK_CLK_GATE_EN <= 1'b0;
			SERIALIZER_EMPHASIS_LEVEL <= {EMPH_W{1'b0}};
		end else begin
			sysref_d_reg <= SYSREF;
			SERIAL_LINK_ENABLE <= link_en_reg;
			SERIALIZER_POWER_DOWN <= ~link_en_reg;
			LINK_CLK_GATE_EN <= link_en_reg;
			SERIALIZER_EMPHASIS_LEVEL <= emph_reg;
			PAYLOAD_READY <= link_en_reg;
			LEMC_PULSE <= 1'b0;
			BLOCK_VALID <= take_blk;
			if (!link_en_reg) begin
				lfsr_reg <= `PARITY_ZERO;
				parity_hold_reg <= `PAR_ZERO;
				blk_cnt_reg <= 5'h00;
				BLOCK_VALID <= 1'b0;
			end else if (sysref_rise) begin
				// sysref restarts lemc; partial multiblock dropped
				blk_cnt_reg <= 5'h00;
				lfsr_reg <= `PARITY_ZERO;
				LEMC_PULSE <= 1'b1;
				BLOCK_VALID <= 1'b0;
			end else if (take_blk) begin
				BLOCK_OUT <= {PAYLOAD_DATA,
					sh_bit ? `HDR_ONE : `HDR_ZERO};
				lfsr_reg <= lfsr_next;
				blk_cnt_reg <= blk_cnt_reg + 5'h01;
				if (blk_cnt_reg == last_blk) begin
					parity_hold_reg <= lfsr_next;
					mb_count_reg <= mb_count_reg + 32'h00000001;
					LEMC_PULSE <= 1'b1;
				end
			end
		end
	end

endmodule // sync_header_fec_link_align

// File: link_fec_assertions.sv
// checker for the fec sync header link block
`timescale 1ns/1ps
module link_fec_chk(
	input wire CLK,
	input wire RST_N,
	input wire [63:0] PAYLOAD_DATA,
	input wire PAYLOAD_VALID,
	input wire PAYLOAD_READY,
	input wire [65:0] BLOCK_OUT,
	input wire BLOCK_VALID,
	input wire LEMC_PULSE,
	input wire SERIAL_LINK_ENABLE,
	input wire SERIALIZER_POWER_DOWN,
	input wire LINK_CLK_GATE_EN,
	input wire SYSREF
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	wire en = SERIAL_LINK_ENABLE;
	wire take = PAYLOAD_VALID && PAYLOAD_READY && en;
	property p_off;
		!en |-> SERIALIZER_POWER_DOWN && !LINK_CLK_GATE_EN;
	endproperty
	a_off: assert property (p_off) else $error("not gated");
	property p_quiet;
		!en && !$past(en) |-> !PAYLOAD_READY && !BLOCK_VALID;
	endproperty
	a_quiet: assert property (p_quiet) else $error("busy off");
	property p_hdr;
		BLOCK_VALID |-> BLOCK_OUT[0] != BLOCK_OUT[1];
	endproperty
	a_hdr: assert property (p_hdr) else $error("bad header");
	property p_take;
		take |=> BLOCK_VALID && BLOCK_OUT[65:2] == $past(PAYLOAD_DATA);
	endproperty
	a_take: assert property (p_take) else $error("block lost");
	property p_only;
		BLOCK_VALID |-> $past(take);
	endproperty
	a_only: assert property (p_only) else $error("stray block");
	property p_sref;
		$rose(SYSREF) && en |-> ##[1:4] LEMC_PULSE;
	endproperty
	a_sref: assert property (p_sref) else $error("no restart");
	property p_lemc;
		LEMC_PULSE |=> !LEMC_PULSE;
	endproperty
	a_lemc: assert property (p_lemc) else $error("long pulse");
	property p_on;
		$rose(en) |-> ##[0:1] PAYLOAD_READY;
	endproperty
	a_on: assert property (p_on) else $error("not ready");
	c_take: cover property (take);
	c_sref: cover property ($rose(SYSREF) && en);
	c_lemc: cover property (LEMC_PULSE);
endmodule // link_fec_chk

bind sync_header_fec_link_align link_fec_chk u_chk (.*);

// File: link_rx_model.sv
// receiver model: own parity, syndrome, sync stream
`timescale 1ns/1ps
`include "link_fec_consts.vh"
module link_rx_model(
	input wire clk,
	input wire rst_n,
	input wire [65:0] blk,
	input wire vld,
	output reg [25:0] syn,
	output reg [31:0] strm,
	output reg done
);
	reg [25:0] own, prev;
	reg [4:0] idx;
	integer i;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev = 0;
			idx = 0;
			done = 0;
		end else begin
			done = 0;
			if (vld) begin
				if (idx == 0)
					own = 0;
				for (i = 2; i < 66; i = i + 1)
					own = {own[24:0], 1'b0} ^ (blk[i] ^ own[25] ? `FEC_POLY : 0);
				strm[idx] = blk[1];
				if (idx == 31) begin
					for (i = 0; i < 27; i = i + 1)
						if (i != 22)
							syn[i < 22 ? 25 - i : 26 - i] = strm[i];
					syn = syn ^ prev;
					prev = own;
					done = 1;
				end
				idx = idx + 1;
			end
		end
	end
endmodule // link_rx_model

// File: tb_sync_header_fec_link_align.sv
// self-checking bench for the fec link block
`timescale 1ns/1ps
module tb_sync_header_fec_link_align;
	reg CLK = 0, RST_N = 0, SYSREF = 0, PAYLOAD_VALID = 0;
	reg S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
	reg S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	reg [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0;
	reg [3:0] S_AXI_WSTRB = 4'hF;
	reg [63:0] PAYLOAD_DATA = 0;
	wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	wire S_AXI_RVALID, PAYLOAD_READY, BLOCK_VALID, LEMC_PULSE, done;
	wire SERIAL_LINK_ENABLE, SERIALIZER_POWER_DOWN, LINK_CLK_GATE_EN;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA, strm;
	wire [65:0] BLOCK_OUT;
	wire [3:0] SERIALIZER_EMPHASIS_LEVEL;
	wire [25:0] syn;
	integer n_mismatch = 0, comparisons = 0, seed = 15976, k, t;
	reg [33:0] qr[$], qm[$];
	sync_header_fec_link_align u_sync_header_fec_link_align (.*);
	link_rx_model u_link_rx_model (.clk(CLK), .rst_n(RST_N),
		.blk(BLOCK_OUT), .vld(BLOCK_VALID), .syn(syn), .strm(strm),
		.done(done));
	initial forever #12.5 CLK = ~CLK;
	task chk(input [33:0] got, input [33:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tick;
		t = t + 1;
		if (t > 200) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	endtask
	task axw(input [31:0] a, input [31:0] d);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		S_AXI_BREADY <= 1;
		t = 0;
		do begin
			@(posedge CLK);
			if (S_AXI_AWREADY === 1)
				S_AXI_AWVALID <= 0;
			if (S_AXI_WREADY === 1)
				S_AXI_WVALID <= 0;
			tick;
		end while (S_AXI_BVALID !== 1);
		S_AXI_BREADY <= 0;
	endtask
	task axr(input [31:0] a, input [33:0] e);
		qr.push_back(e);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		S_AXI_RREADY <= 1;
		t = 0;
		do begin
			@(posedge CLK);
			if (S_AXI_ARREADY === 1)
				S_AXI_ARVALID <= 0;
			tick;
		end while (S_AXI_RVALID !== 1);
		S_AXI_RREADY <= 0;
	endtask
	task blocks(input integer n);
		for (k = 0; k < n; k = k + 1) begin
			if (k % 32 == 31)
				qm.push_back({26'h0, 5'h10, 1'b1});
			PAYLOAD_DATA <= {$random(seed), $random(seed)};
			PAYLOAD_VALID <= 1;
			t = 0;
			do begin
				@(posedge CLK);
				tick;
			end while (PAYLOAD_READY !== 1);
		end
		PAYLOAD_VALID <= 0;
	endtask
	always @(posedge CLK)
		if (S_AXI_RVALID === 1 && S_AXI_RREADY === 1)
			chk({S_AXI_RRESP, S_AXI_RDATA}, qr.pop_front());
	always @(negedge CLK)
		if (done === 1)
			chk({syn, strm[31:27], strm[22]}, qm.pop_front());
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1;
		@(posedge CLK);
		axr(32'h0, 34'h2);
		axw(32'h4, 32'h9);
		axr(32'h4, 34'h9);
		chk(SERIALIZER_EMPHASIS_LEVEL, 34'h9);
		axr(32'h10, 34'h300000000);
		axw(32'h0, 32'h3);
		axw(32'h4, 32'h5);
		axr(32'h4, 34'h9);
		$display("test regs done");
		SYSREF <= 1;
		@(posedge CLK);
		SYSREF <= 0;
		repeat (4) @(posedge CLK);
		blocks(96);
		t = 0;
		while (qm.size() > 0) begin
			@(posedge CLK);
			tick;
		end
		axw(32'h0, 32'h2);
		repeat (3) @(posedge CLK);
		chk({SERIALIZER_POWER_DOWN, LINK_CLK_GATE_EN, PAYLOAD_READY}, 34'h4);
		$display("test stream done");
		print_verdict;
	end
endmodule // tb_sync_header_fec_link_align
